// >>> core/ibc_map.svh
`ifndef IBC_MAP_SVH
`define IBC_MAP_SVH
`define IBC_OFF_CTRL 8'h94
`define IBC_OFF_SLOT 8'h98
`define IBC_OFF_STAT 8'h9c
`define IBC_CTRL_EN 3
`define IBC_CTRL_TYPE 2
`define IBC_CTRL_MASTER_SELECT_BIT0 1
`define IBC_CTRL_MASTER_SELECT_BIT1 0
`define IBC_CTRL_MASK 8'h0f
`define IBC_CTRL_RST 8'h00
`define IBC_SLOT_POS_HI 1
`define IBC_SLOT_POS_LO 0
`define IBC_SLOT_RATE 2
`define IBC_SLOT_RST 3'h0
`define IBC_STAT_UNDER 0
`define IBC_STAT_RSVD 1
`define IBC_STAT_LVL_LO 4
`define IBC_BASE_SLOTS 8'h20
`define IBC_FRAME_SHIFT 5
`define IBC_LAST_BIT 3'h7
`define IBC_FIFO_DEPTH 8
`define IBC_WORD_W 16
`endif

// >>> core/ibc_pkg.sv
`default_nettype none
package ibc_pkg;
  typedef enum logic [1:0] {
    msel_slave = 2'b00,
    msel_master2 = 2'b01,
    msel_master4 = 2'b10,
    msel_rsvd = 2'b11
  } ibc_msel_e;

  typedef struct packed {
    logic [6:0] slot;
    logic [2:0] bit_idx;
  } ibc_timer_s;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [2:0] slot_cfg;
    logic underrun;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [7:0] dsh;
    logic [7:0] ssh;
    logic data_o;
    logic sig_o;
    logic drive_n;
    logic sync_o;
    logic sync_oe_n;
  } ibc_core_s;
endpackage
`default_nettype wire

// >>> core/ibc_slot_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ibc_slot_if;
  logic tick;
  logic sync_in;
  logic follow;
  logic [7:0] frame_len;
  logic [6:0] slot;
  logic [2:0] bit_idx;
  logic frame_start;
  modport timer (input tick, input sync_in, input follow, input frame_len,
    output slot, output bit_idx, output frame_start);
  modport core (output tick, output sync_in, output follow, output frame_len,
    input slot, input bit_idx, input frame_start);
endinterface
`default_nettype wire

// >>> core/ibc_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module ibc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic s_valid,
  input wire logic [WIDTH-1:0] s_data,
  output logic s_ready,
  output logic m_valid,
  output logic [WIDTH-1:0] m_data,
  input wire logic m_ready,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic not_full;
  } ibc_fifo_s;
  ibc_fifo_s st_r, st_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  assign push = ce && s_valid && st_r.not_full;
  assign pop = ce && m_ready && (st_r.cnt != '0);

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.wp = (st_r.wp == AW'(DEPTH - 1)) ? '0 : st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = (st_r.rp == AW'(DEPTH - 1)) ? '0 : st_r.rp + 1'b1;
    end
    st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    st_nxt.not_full = (st_nxt.cnt != (AW+1)'(DEPTH));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '{wp: '0, rp: '0, cnt: '0, not_full: 1'b1};
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // storage needs no reset; m_data shows mem[rp] even when empty, and is used only while cnt is nonzero
  always_ff @(posedge pclk) begin
    if (push) begin
      mem[st_r.wp] <= s_data;
    end
  end

  assign s_ready = st_r.not_full;
  assign m_valid = (st_r.cnt != '0);
  assign m_data = mem[st_r.rp];
  assign level = st_r.cnt;
endmodule
`default_nettype wire

// >>> core/ibc_slot_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "ibc_map.svh"
module ibc_slot_timer
  import ibc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  ibc_slot_if.timer sif
);
  ibc_timer_s st_r, st_nxt;
  ibc_timer_s cur;
  logic [7:0] slot_inc;

  always_comb begin
    cur = st_r;
    // a slave realigns on the master's sync, so its count never drifts
    if (sif.follow && sif.sync_in) begin
      cur = '0;
    end
    slot_inc = {1'b0, cur.slot} + 8'h01;
    st_nxt = st_r;
    if (sif.tick) begin
      if (cur.bit_idx == `IBC_LAST_BIT) begin
        st_nxt.bit_idx = '0;
        st_nxt.slot = (slot_inc >= sif.frame_len) ? '0 : slot_inc[6:0];
      end else begin
        st_nxt.bit_idx = cur.bit_idx + 3'h1;
        st_nxt.slot = cur.slot;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign sif.slot = cur.slot;
  assign sif.bit_idx = cur.bit_idx;
  assign sif.frame_start = (cur.slot == '0) && (cur.bit_idx == '0);
endmodule
`default_nettype wire

// >>> core/ibc_core.sv
// Overview of operation
// - lower bus rate: exactly two framers share one bus for data and signalling.
// - higher bus rate: all four framers share one bus for data and signalling.
// - type bit 0 interleaves byte by byte, 1 frame by frame.
// - enable bit 1 turns shared-bus operation on, 0 turns it off.
// - select 00 slave, 01 master of two, 10 master of four, 11 reserved.
// - byte interleave needs no synchrony between sharing framers' receive lines.
`timescale 1ns/1ps
`default_nettype none
`include "ibc_map.svh"
module ibc_core
  import ibc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic s_valid,
  input wire logic [15:0] s_data,
  output logic s_ready,
  input wire logic bus_bit_en,
  output logic bus_data_o,
  output logic bus_data_oe_n,
  output logic bus_sig_o,
  output logic bus_sig_oe_n,
  input wire logic bus_sync_i,
  output logic bus_sync_o,
  output logic bus_sync_oe_n
);
  ibc_core_s st_r, st_nxt;
  ibc_msel_e msel;
  logic en, frame_mode, rsvd, follow, own, pop, access, wr, rd;
  logic [1:0] lane_shift, lane, lane_mask, pos;
  logic [7:0] frame_len;
  logic [15:0] word;
  logic m_valid;
  logic [15:0] m_data;
  logic [3:0] level;

  ibc_slot_if sif ();

  ibc_fifo #(
    .WIDTH(`IBC_WORD_W),
    .DEPTH(`IBC_FIFO_DEPTH)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .s_valid(s_valid),
    .s_data(s_data),
    .s_ready(s_ready),
    .m_valid(m_valid),
    .m_data(m_data),
    .m_ready(pop),
    .level(level)
  );

  ibc_slot_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .sif(sif.timer)
  );

  // configuration decode
  always_comb begin
    en = st_r.ctrl[`IBC_CTRL_EN];
    frame_mode = st_r.ctrl[`IBC_CTRL_TYPE];
    msel = ibc_msel_e'({st_r.ctrl[`IBC_CTRL_MASTER_SELECT_BIT1], st_r.ctrl[`IBC_CTRL_MASTER_SELECT_BIT0]});
    rsvd = en && (msel == msel_rsvd);
    follow = 1'b0;
    pos = 2'h0;
    lane_shift = 2'h0;
    if (en) begin
      unique case (msel)
        msel_slave: begin
          follow = 1'b1;
          pos = st_r.slot_cfg[`IBC_SLOT_POS_HI:`IBC_SLOT_POS_LO];
          lane_shift = st_r.slot_cfg[`IBC_SLOT_RATE] ? 2'h2 : 2'h1;
        end
        msel_master2: lane_shift = 2'h1;
        msel_master4: lane_shift = 2'h2;
        // reserved code falls back to stand-alone rather than corrupt a shared bus
        msel_rsvd: lane_shift = 2'h0;
      endcase
    end
    // stand-alone: one lane, own frame, select and type have no effect
    frame_len = `IBC_BASE_SLOTS << lane_shift;
    lane_mask = 2'((3'h1 << lane_shift) - 3'h1);
  end

  // slot ownership: byte mode rotates per slot, frame mode per 32-slot block
  always_comb begin
    if (frame_mode) begin
      lane = 2'(sif.slot >> `IBC_FRAME_SHIFT) & lane_mask;
    end else begin
      lane = sif.slot[1:0] & lane_mask;
    end
    // byte mode rotates per slot on the shared slot count, so no receive-line synchrony is assumed
    own = (lane == pos);
  end

  assign sif.tick = bus_bit_en;
  assign sif.sync_in = bus_bit_en && bus_sync_i;
  assign sif.follow = follow;
  assign sif.frame_len = frame_len;

  assign pop = bus_bit_en && own && (sif.bit_idx == '0) && m_valid;
  assign word = m_valid ? m_data : '0;

  assign access = psel && penable && !st_r.pready;
  assign wr = access && pwrite;
  assign rd = access && !pwrite;

  always_comb begin
    st_nxt = st_r;
    st_nxt.pready = access;
    if (!access) begin
      st_nxt.pslverr = 1'b0;
    end
    if (wr) begin
      st_nxt.pslverr = 1'b0;
      unique case (paddr)
        `IBC_OFF_CTRL: st_nxt.ctrl = pwdata[7:0] & `IBC_CTRL_MASK;
        `IBC_OFF_SLOT: st_nxt.slot_cfg = pwdata[2:0];
        `IBC_OFF_STAT: begin
          if (pwdata[`IBC_STAT_UNDER]) begin
            st_nxt.underrun = 1'b0;
          end
        end
        default: st_nxt.pslverr = 1'b1;
      endcase
    end
    if (rd) begin
      st_nxt.pslverr = 1'b0;
      st_nxt.prdata = '0;
      unique case (paddr)
        `IBC_OFF_CTRL: st_nxt.prdata[7:0] = st_r.ctrl;
        `IBC_OFF_SLOT: st_nxt.prdata[2:0] = st_r.slot_cfg;
        `IBC_OFF_STAT: begin
          st_nxt.prdata[`IBC_STAT_UNDER] = st_r.underrun;
          st_nxt.prdata[`IBC_STAT_RSVD] = rsvd;
          st_nxt.prdata[`IBC_STAT_LVL_LO +: 4] = level;
        end
        default: st_nxt.pslverr = 1'b1;
      endcase
    end
    if (bus_bit_en) begin
      st_nxt.drive_n = !own;
      if (own && (sif.bit_idx == '0)) begin
        st_nxt.data_o = word[7];
        st_nxt.sig_o = word[15];
        st_nxt.dsh = {word[6:0], 1'b0};
        st_nxt.ssh = {word[14:8], 1'b0};
        // set beats a same-cycle clear
        if (!m_valid) begin
          st_nxt.underrun = 1'b1;
        end
      end else if (own) begin
        st_nxt.data_o = st_r.dsh[7];
        st_nxt.sig_o = st_r.ssh[7];
        st_nxt.dsh = {st_r.dsh[6:0], 1'b0};
        st_nxt.ssh = {st_r.ssh[6:0], 1'b0};
      end else begin
        st_nxt.data_o = 1'b0;
        st_nxt.sig_o = 1'b0;
      end
      // master and stand-alone framers source the frame sync, slaves listen
      st_nxt.sync_o = !follow && sif.frame_start;
      st_nxt.sync_oe_n = follow;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '{ctrl: `IBC_CTRL_RST, slot_cfg: `IBC_SLOT_RST, underrun: 1'b0,
        pready: 1'b0, pslverr: 1'b0, prdata: '0, dsh: '0, ssh: '0,
        data_o: 1'b0, sig_o: 1'b0, drive_n: 1'b1, sync_o: 1'b0, sync_oe_n: 1'b1};
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign bus_data_o = st_r.data_o;
  assign bus_data_oe_n = st_r.drive_n;
  assign bus_sig_o = st_r.sig_o;
  assign bus_sig_oe_n = st_r.drive_n;
  assign bus_sync_o = st_r.sync_o;
  assign bus_sync_oe_n = st_r.sync_oe_n;
endmodule
`default_nettype wire

// >>> tb/ibc_core_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ibc_core_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic bus_bit_en,
  input wire logic bus_data_o,
  input wire logic bus_data_oe_n,
  input wire logic bus_sig_o,
  input wire logic bus_sig_oe_n,
  input wire logic bus_sync_o
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic tk, mp;
  assign tk = psel && penable && !pready && ce;
  assign mp = paddr == 8'h94 || paddr == 8'h98 || paddr == 8'h9c;
  property p_ack; tk |=> pready; endproperty
  a_ack: assert property (p_ack) else $error("late ready");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("long ready");
  property p_err; tk && !mp |=> pready && pslverr; endproperty
  a_err: assert property (p_err) else $error("no error");
  property p_ok; tk && mp |=> !pslverr; endproperty
  a_ok: assert property (p_ok) else $error("bad error");
  property p_hi; pready && !pwrite && paddr == 8'h94 |-> prdata[31:4] == 28'h0; endproperty
  a_hi: assert property (p_hi) else $error("ctrl high bits");
  property p_quiet; bus_data_oe_n |-> !bus_data_o && !bus_sig_o; endproperty
  a_quiet: assert property (p_quiet) else $error("unowned drive");
  // a sourced frame sync always marks a slot this framer owns
  property p_pair; bus_sync_o |-> !bus_data_oe_n && !bus_sig_oe_n; endproperty
  a_pair: assert property (p_pair) else $error("sync outside own slot");
  // pins may only move at the edge that ends a bit strobe
  property p_step;
    !$past(bus_bit_en) |-> $stable({bus_data_o, bus_sig_o, bus_data_oe_n, bus_sync_o});
  endproperty
  a_step: assert property (p_step) else $error("pin moved off strobe");
  c_err: cover property (pready && pslverr);
  c_drv: cover property ($fell(bus_data_oe_n));
  c_sync: cover property ($rose(bus_sync_o));
endmodule
bind ibc_core ibc_core_monitor i_mon (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .bus_bit_en, .bus_data_o, .bus_data_oe_n, .bus_sig_o,
  .bus_sig_oe_n, .bus_sync_o);
`default_nettype wire

// >>> tb/ibc_bus_peer.sv
`timescale 1ns/1ps
`default_nettype none
module ibc_bus_peer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] frame_slots,
  output logic bus_bit_en,
  output logic bus_sync_i,
  input wire logic data_o,
  input wire logic data_oe_n,
  input wire logic sig_o,
  input wire logic sync_o,
  input wire logic sync_oe_n
);
  logic [1:0] div;
  logic got, drv;
  logic [9:0] pos, rp;
  logic own [128];
  logic [7:0] dat [128];
  logic [7:0] sg [128];
  // wired sync pin: the driving framer wins, else this peer acts as master
  assign bus_sync_i = sync_oe_n ? drv : sync_o;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div <= 2'h0;
      bus_bit_en <= 1'b0;
      got <= 1'b0;
      drv <= 1'b0;
      pos <= 10'h3ff;
    end else begin
      div <= div + 2'h1;
      bus_bit_en <= (div == 2'h3); // one shared strobe, one reference
      got <= bus_bit_en;
      if (div == 2'h3) begin
        rp = ({1'b0, pos} + 11'h1 == {frame_slots, 3'h0}) ? 10'h0 : pos + 10'h1;
        pos <= rp;
        drv <= (rp == 10'h0);
      end
      if (got) begin
        rp = (!sync_oe_n && sync_o) ? 10'h0 : pos;
        pos <= rp;
        if (!data_oe_n) begin
          own[rp[9:3]] <= 1'b1;
          dat[rp[9:3]][3'h7 - rp[2:0]] <= data_o;
          sg[rp[9:3]][3'h7 - rp[2:0]] <= sig_o;
        end
      end
    end
  end
  task automatic clr();
    for (int i = 0; i < 128; i++) begin
      own[i] = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic pclk, presetn, ce, psel, penable, pwrite, s_valid, bus_bit_en, bus_sync_i, e;
  logic pready, pslverr, s_ready, bus_data_o, bus_data_oe_n, bus_sig_o, bus_sig_oe_n;
  logic bus_sync_o, bus_sync_oe_n;
  logic [7:0] paddr, slots;
  logic [15:0] s_data;
  logic [31:0] pwdata, prdata, r, seed, v;
  int fail_count, num_checks, k;
  logic [7:0] t_ctrl [8] = '{8'h04, 8'h0a, 8'h0e, 8'h09, 8'h0d, 8'h08, 8'h0c, 8'h0b};
  logic [2:0] t_cfg [8] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h6, 3'h0};
  logic [7:0] t_len [8] = '{8'h20, 8'h40, 8'h40, 8'h80, 8'h80, 8'h40, 8'h80, 8'h20};
  ibc_core i_ibc_core (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .s_valid, .s_data, .s_ready, .bus_bit_en, .bus_data_o,
    .bus_data_oe_n, .bus_sig_o, .bus_sig_oe_n, .bus_sync_i, .bus_sync_o, .bus_sync_oe_n);
  ibc_bus_peer i_ibc_bus_peer (.pclk, .presetn, .frame_slots(slots), .bus_bit_en,
    .bus_sync_i, .data_o(bus_data_o), .data_oe_n(bus_data_oe_n), .sig_o(bus_sig_o),
    .sync_o(bus_sync_o), .sync_oe_n(bus_sync_oe_n));
  always #5 pclk = ~pclk;
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic own_exp(logic [7:0] c, logic [2:0] g, int s);
    logic [1:0] m;
    int n;
    m = {c[0], c[1]};
    n = (m == 2'b10 || (m == 2'b00 && g[2])) ? 4 : 2;
    if (!c[3] || m == 2'b11) return 1'b1;
    return (c[2] ? s / 32 : s % n) == (m == 2'b00 ? int'(g[1:0]) : 0);
  endfunction
  task automatic chk(string w, logic [31:0] x, logic [31:0] g);
    num_checks++;
    if (g !== x) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", w, x, g);
    end
  endtask
  // an idle edge before each setup keeps psel from being driven twice in one step
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      fail_count++;
      $display("[ERR] pready expected 1 seen 0");
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #900000;
    fail_count++;
    $display("[ERR] watchdog expected done seen timeout");
    wrap_up();
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    s_valid = 1'b0;
    s_data = 16'h0;
    slots = 8'h20;
    seed = 32'h0000a0ee;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("s_ready", 32'h1, s_ready);
    apb(1'b0, 8'h94, 32'h0);
    chk("ctrl reset", 32'h0, r);
    repeat (6) begin
      v = rnd();
      apb(1'b1, 8'h94, v);
      apb(1'b0, 8'h94, 32'h0);
      chk("ctrl", v & 32'hf, r);
    end
    apb(1'b0, 8'h90, 32'h0);
    chk("unmapped", 32'h1, {r[30:0], e});
    $display("register test done");
    for (int t = 0; t < 8; t++) begin
      v = rnd();
      s_data <= v[15:0];
      // the store is kept fed before interleaving starts
      s_valid <= 1'b1;
      slots <= t_len[t];
      apb(1'b1, 8'h98, {29'h0, t_cfg[t]});
      apb(1'b1, 8'h94, {24'h0, t_ctrl[t]});
      // long enough to finish a stale long frame and resync
      repeat (40 * t_len[t] + 2048) @(posedge pclk);
      i_ibc_bus_peer.clr();
      repeat (33 * t_len[t]) @(posedge pclk);
      for (int s = 0; s < t_len[t]; s++) begin
        chk("owned", own_exp(t_ctrl[t], t_cfg[t], s), i_ibc_bus_peer.own[s]);
        if (own_exp(t_ctrl[t], t_cfg[t], s)) begin
          chk("word", v[15:0], {i_ibc_bus_peer.sg[s], i_ibc_bus_peer.dat[s]});
        end
      end
      chk("sync oe_n", t_ctrl[t][3] && t_ctrl[t][1:0] == 2'b00, bus_sync_oe_n);
      apb(1'b0, 8'h9c, 32'h0);
      chk("reserved", t_ctrl[t][1:0] == 2'b11, r[1]);
      $display("mode test %0d done", t);
    end
    s_valid <= 1'b0;
    apb(1'b1, 8'h94, 32'h0);
    repeat (600) @(posedge pclk);
    i_ibc_bus_peer.clr();
    repeat (1100) @(posedge pclk);
    chk("empty word", 32'h0, {i_ibc_bus_peer.sg[3], i_ibc_bus_peer.dat[3]});
    apb(1'b0, 8'h9c, 32'h0);
    chk("underrun", 32'h1, r & 32'hf3);
    s_valid <= 1'b1;
    k = 0;
    while (s_ready !== 1'b0 && k < 40) begin
      @(posedge pclk);
      k++;
    end
    chk("refused", 32'h0, s_ready);
    apb(1'b0, 8'h9c, 32'h0);
    chk("level full", 32'h1, r[7:4] >= 4'h7);
    apb(1'b1, 8'h9c, 32'h1);
    apb(1'b0, 8'h9c, 32'h0);
    chk("underrun clear", 32'h0, r[0]);
    // with the enable low nothing may drain, though the bus strobe keeps running
    s_valid <= 1'b0;
    ce <= 1'b0;
    repeat (600) @(posedge pclk);
    ce <= 1'b1;
    apb(1'b0, 8'h9c, 32'h0);
    chk("frozen level", 32'h1, r[7:4] >= 4'h6);
    $display("buffer test done");
    wrap_up();
  end
endmodule
`default_nettype wire
